// ### hdl/ufa_core.sv
/*
 USB device-level control: function address with deferred update, bus
 reset effects, software reset, suspend/resume, remote wakeup, iso update.
 Assumes the serial engine gives one-cycle event pulses on mclk.
*/
// Contract
// - Seven-bit function address held in a writable register.
// - New address takes effect only when the current transfer ends.
// - Pending flag bit 7 sets on write, clears when address active.
// - Bus reset detection sets bus reset flag bit 3.
// - Bus reset zeroes function address and flushes endpoint FIFOs.
// - Bus reset clears endpoint status registers and index to zero.
// - Bus reset enables all interrupts except suspend, clears flags.
// - Bus reset raises reset interrupt when enabled.
// - Writing one to bus reset bit resets the whole controller except the bus slave ack and read data registers.
// - Suspend entered on suspend signalling only when detection enabled.
// - Suspend interrupt raised only when its enable is set.
// - Suspend left on resume, bus reset or device reset.
// - Suspend exit on resume, bus reset or remote wakeup also wakes the internal oscillator; device reset does not.
// - Resume signalling leaves suspend, raises resume interrupt if enabled.
// - Remote wakeup bit drives resume signalling until firmware clears it.
// - Deferred iso update holds new iso packet until next frame start.
// - Iso IN token before frame start gets a zero-length packet.
// - One deferred update setting governs all iso endpoints.
// - Controller inhibited after reset; clearing inhibit bit enables it.
// - Inhibit returns to one only by reset; firmware ones ignored.
// - Reading an interrupt flag register clears all its flags.
`timescale 1ns/100ps
module ufa_core
    import ufa_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Wishbone slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    // Serial engine events
    input  wire logic       bus_reset_seen,
    input  wire logic       suspend_seen,
    input  wire logic       resume_seen,
    input  wire logic       transfer_done,
    input  wire logic       sof_seen,
    input  wire logic       iso_loaded,
    input  wire logic       iso_in_token,
    input  wire logic       token_valid,
    input  wire logic [6:0] token_addr,
    // Device side outputs
    output logic            token_accept,
    output logic            iso_send_zero,
    output logic            iso_release,
    output logic            fifo_flush,
    output logic            ep_regs_clear,
    output logic            drive_resume,
    output logic            osc_wake,
    output logic            link_enabled,
    output logic            suspended,
    output logic            irq_out
);
    // ****************************************
    // Registers
    // ****************************************
    logic [6:0] addr_new_reg, addr_act_reg;
    logic       pend_reg;
    logic       inh_reg, iso_reg, wake_reg, susp_reg, suspend_detect_enable_reg, brst_reg;
    logic [2:0] iflag_reg, ien_reg;
    logic [3:0] index_reg;
    logic       iso_hold_reg;
    logic [2:0] srst_cnt_reg;
    logic [31:0] dat_reg;
    logic       ack_reg, acc_reg, zero_reg, rel_reg, flush_reg, osc_reg;
    logic       len_reg, irq_reg;

    // ****************************************
    // Decode
    // ****************************************
    wire req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr       = req & wb_we_i & wb_sel_i[0];
    wire rd       = req & ~wb_we_i;
    wire wr_addr  = wr & (wb_adr_i == UFA_FUNC_ADDR_OFF);
    wire wr_ctrl  = wr & (wb_adr_i == UFA_DEV_CTRL_OFF);
    wire wr_ien   = wr & (wb_adr_i == UFA_IRQ_EN_OFF);
    wire wr_index = wr & (wb_adr_i == UFA_INDEX_OFF);
    wire rd_flag  = rd & (wb_adr_i == UFA_IRQ_FLAG_OFF);
    // Software reset stretched so every register but the bus slave ack and read data sees it
    wire soft_rst = wr_ctrl & wb_dat_i[UFA_BRST_BIT];
    wire srst     = reset | (srst_cnt_reg != 3'h0);
    wire busrst   = bus_reset_seen & ~inh_reg;
    wire susp_in  = suspend_seen & suspend_detect_enable_reg & ~susp_reg & ~inh_reg;
    wire wake_in  = resume_seen | busrst | (wr_ctrl & wb_dat_i[UFA_WAKE_BIT]);
    wire resume_ev = resume_seen & susp_reg;
    wire [7:0] ctrl_rd = {iso_reg, 2'h0, inh_reg, brst_reg, wake_reg, susp_reg, suspend_detect_enable_reg};
    wire [7:0] rdmux =
        (wb_adr_i == UFA_FUNC_ADDR_OFF) ? {pend_reg, addr_new_reg} :
        (wb_adr_i == UFA_DEV_CTRL_OFF)  ? ctrl_rd :
        (wb_adr_i == UFA_IRQ_FLAG_OFF)  ? {5'h00, iflag_reg} :
        (wb_adr_i == UFA_IRQ_EN_OFF)    ? {5'h00, ien_reg} :
        (wb_adr_i == UFA_INDEX_OFF)     ? {4'h0, index_reg} : 8'h00;
    wire [2:0] iflag_set = {busrst & ien_reg[UFA_IRQ_RESET],
                            resume_ev & ien_reg[UFA_IRQ_RESUME],
                            susp_in & ien_reg[UFA_IRQ_SUSP]};

    // ****************************************
    // Bus slave
    // ****************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            dat_reg <= rd ? {24'h000000, rdmux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            srst_cnt_reg <= 3'h0;
        end else if (soft_rst) begin
            srst_cnt_reg <= 3'(UFA_SRST_CYC);
        end else if (srst_cnt_reg != 3'h0) begin
            srst_cnt_reg <= srst_cnt_reg - 3'h1;
        end
    end

    // ****************************************
    // Function address
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_new_reg <= UFA_ADDR_RST;
            addr_act_reg <= UFA_ADDR_RST;
            pend_reg     <= 1'b0;
        end else if (busrst) begin
            addr_new_reg <= UFA_ADDR_RST;
            addr_act_reg <= UFA_ADDR_RST;
            pend_reg     <= 1'b0;
        end else if (wr_addr) begin
            addr_new_reg <= wb_dat_i[6:0];
            pend_reg     <= 1'b1;
        end else if (pend_reg && transfer_done) begin
            addr_act_reg <= addr_new_reg;
            pend_reg     <= 1'b0;
        end
    end

    // ****************************************
    // Device control
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            iso_reg   <= UFA_CTRL_RST[UFA_ISO_BIT];
            inh_reg   <= UFA_CTRL_RST[UFA_INH_BIT];
            len_reg   <= ~UFA_CTRL_RST[UFA_INH_BIT];
            brst_reg  <= UFA_CTRL_RST[UFA_BRST_BIT];
            wake_reg  <= UFA_CTRL_RST[UFA_WAKE_BIT];
            susp_reg  <= UFA_CTRL_RST[UFA_SUSP_BIT];
            suspend_detect_enable_reg <= UFA_CTRL_RST[UFA_SUSPEND_DETECT_ENABLE_BIT];
        end else begin
            if (wr_ctrl) begin
                len_reg   <= ~(inh_reg & wb_dat_i[UFA_INH_BIT]);
                iso_reg   <= wb_dat_i[UFA_ISO_BIT];
                suspend_detect_enable_reg <= wb_dat_i[UFA_SUSPEND_DETECT_ENABLE_BIT];
                wake_reg  <= wb_dat_i[UFA_WAKE_BIT];
                inh_reg   <= inh_reg & wb_dat_i[UFA_INH_BIT];
            end
            brst_reg <= busrst | (brst_reg & ~busrst);
            if (susp_in) begin
                susp_reg <= 1'b1;
            end else if (wake_in) begin
                susp_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupts, index
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            iflag_reg <= 3'h0;
            irq_reg   <= 1'b0;
            ien_reg   <= UFA_IEN_RST;
            index_reg <= UFA_INDEX_RST;
        end else if (busrst) begin
            iflag_reg <= 3'(1 << UFA_IRQ_RESET) & {3{ien_reg[UFA_IRQ_RESET]}};
            irq_reg   <= ien_reg[UFA_IRQ_RESET];
            ien_reg   <= UFA_IEN_BUSRST | (ien_reg & 3'h1);
            index_reg <= UFA_INDEX_RST;
        end else begin
            // Set wins over the read clear
            iflag_reg <= (rd_flag ? 3'h0 : iflag_reg) | iflag_set;
            irq_reg   <= |((rd_flag ? 3'h0 : iflag_reg) | iflag_set);
            if (wr_ien) begin
                ien_reg <= wb_dat_i[2:0];
            end
            if (wr_index) begin
                index_reg <= wb_dat_i[3:0];
            end
        end
    end

    // ****************************************
    // Iso deferral and token filter
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            iso_hold_reg <= 1'b0;
            acc_reg <= 1'b0;
            zero_reg <= 1'b0;
            rel_reg <= 1'b0;
            flush_reg <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            if (iso_loaded && iso_reg) begin
                iso_hold_reg <= 1'b1;
            end else if (sof_seen) begin
                iso_hold_reg <= 1'b0;
            end
            rel_reg   <= sof_seen & iso_hold_reg;
            zero_reg  <= iso_in_token & iso_hold_reg & ~sof_seen;
            acc_reg   <= token_valid & ~inh_reg & (token_addr == addr_act_reg);
            flush_reg <= busrst;
            osc_reg   <= susp_reg & wake_in;
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = dat_reg;
    assign token_accept  = acc_reg;
    assign iso_send_zero = zero_reg;
    assign iso_release   = rel_reg;
    assign fifo_flush    = flush_reg;
    assign ep_regs_clear = flush_reg;
    assign drive_resume  = wake_reg;
    assign osc_wake      = osc_reg;
    assign link_enabled  = len_reg;
    assign suspended     = susp_reg;
    assign irq_out       = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    property p_pend_set;
        @(posedge mclk) disable iff (srst) wr_addr && !busrst |=> pend_reg;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");
    property p_addr_hold;
        @(posedge mclk) disable iff (srst)
            pend_reg && !transfer_done && !busrst |=> $stable(addr_act_reg);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed early");
    property p_addr_take;
        @(posedge mclk) disable iff (srst)
            pend_reg && transfer_done && !wr_addr && !busrst
            |=> !pend_reg && addr_act_reg == $past(addr_new_reg);
    endproperty
    a_addr_take: assert property (p_addr_take) else $error("address not taken");
    property p_busrst_addr;
        @(posedge mclk) disable iff (srst) busrst |=> addr_act_reg == 7'h00 && brst_reg;
    endproperty
    a_busrst_addr: assert property (p_busrst_addr) else $error("bus reset effects");
    property p_inh_sticky;
        @(posedge mclk) disable iff (srst) !inh_reg |=> !inh_reg;
    endproperty
    a_inh_sticky: assert property (p_inh_sticky) else $error("inhibit reset by write");
    property p_susp_gate;
        @(posedge mclk) disable iff (srst) !suspend_detect_enable_reg && !susp_reg |=> !susp_reg;
    endproperty
    a_susp_gate: assert property (p_susp_gate) else $error("suspend while disabled");
    property p_wake_exit;
        @(posedge mclk) disable iff (srst) susp_reg && resume_seen |=> !susp_reg ##1 1'b1;
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("no resume exit");
    property p_tok;
        @(posedge mclk) disable iff (srst)
            token_valid && token_addr != addr_act_reg |=> !token_accept;
    endproperty
    a_tok: assert property (p_tok) else $error("foreign token accepted");
    property p_zero;
        @(posedge mclk) disable iff (srst)
            iso_hold_reg && iso_in_token && !sof_seen |=> iso_send_zero;
    endproperty
    a_zero: assert property (p_zero) else $error("no zero length packet");

    // ****************************************
    // Reset, interrupt and iso checks
    // ****************************************
    sequence s_srst_end;
        srst ##1 !srst;
    endsequence

    sequence s_iso_arm;
        iso_loaded && iso_reg;
    endsequence

    property p_soft_hold;
        @(posedge mclk) disable iff (reset) soft_rst |=> srst [*4];
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft reset too short");

    property p_soft_defaults;
        @(posedge mclk) disable iff (reset) s_srst_end |-> inh_reg && !link_enabled;
    endproperty
    a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset values");

    property p_len_mirror;
        @(posedge mclk) disable iff (srst) link_enabled == !inh_reg;
    endproperty
    a_len_mirror: assert property (p_len_mirror) else $error("enable output wrong");

    property p_irq_mirror;
        @(posedge mclk) disable iff (srst) irq_out == (|iflag_reg);
    endproperty
    a_irq_mirror: assert property (p_irq_mirror) else $error("irq output wrong");

    property p_busrst_ien;
        @(posedge mclk) disable iff (srst) busrst |=> ien_reg[UFA_IRQ_RESET] && ien_reg[UFA_IRQ_RESUME];
    endproperty
    a_busrst_ien: assert property (p_busrst_ien) else $error("bus reset enables");

    property p_busrst_index;
        @(posedge mclk) disable iff (srst) busrst |=> index_reg == UFA_INDEX_RST && ep_regs_clear;
    endproperty
    a_busrst_index: assert property (p_busrst_index) else $error("bus reset index");

    property p_busrst_irq;
        @(posedge mclk) disable iff (srst) busrst && ien_reg[UFA_IRQ_RESET] |=> iflag_reg[UFA_IRQ_RESET];
    endproperty
    a_busrst_irq: assert property (p_busrst_irq) else $error("no reset irq");

    property p_susp_irq;
        @(posedge mclk) disable iff (srst) susp_in && !busrst |=> iflag_reg[UFA_IRQ_SUSP] == $past(ien_reg[UFA_IRQ_SUSP]);
    endproperty
    a_susp_irq: assert property (p_susp_irq) else $error("suspend irq wrong");

    property p_resume_irq;
        @(posedge mclk) disable iff (srst) resume_ev && ien_reg[UFA_IRQ_RESUME] && !busrst |=> iflag_reg[UFA_IRQ_RESUME];
    endproperty
    a_resume_irq: assert property (p_resume_irq) else $error("no resume irq");

    property p_rd_clear;
        @(posedge mclk) disable iff (srst) rd_flag && iflag_set == 3'h0 && !busrst |=> iflag_reg == 3'h0;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");

    property p_osc;
        @(posedge mclk) disable iff (srst) susp_reg && wake_in |=> osc_wake;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator not woken");

    property p_iso_arm;
        @(posedge mclk) disable iff (srst) s_iso_arm |=> iso_hold_reg;
    endproperty
    a_iso_arm: assert property (p_iso_arm) else $error("iso packet not held");

    property p_iso_release;
        @(posedge mclk) disable iff (srst) sof_seen && iso_hold_reg |=> iso_release;
    endproperty
    a_iso_release: assert property (p_iso_release) else $error("iso packet not released");

    property p_wake_drive;
        @(posedge mclk) disable iff (srst) wr_ctrl && wb_dat_i[UFA_WAKE_BIT] |=> drive_resume;
    endproperty
    a_wake_drive: assert property (p_wake_drive) else $error("no resume drive");

    property p_inh_write;
        @(posedge mclk) disable iff (srst) wr_ctrl && !wb_dat_i[UFA_INH_BIT] |=> !inh_reg && link_enabled;
    endproperty
    a_inh_write: assert property (p_inh_write) else $error("enable write lost");

    property p_brst_flag;
        @(posedge mclk) disable iff (srst) brst_reg |=> brst_reg;
    endproperty
    a_brst_flag: assert property (p_brst_flag) else $error("bus reset flag lost");
endmodule : ufa_core

// ### include/ufa_pkg.sv
/*
 Package for the USB function address and device control block: register
 offsets, field positions, reset values and timing counts.
 Assumes a Wishbone classic slave with byte-wide registers in low bits.
*/
package ufa_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] UFA_FUNC_ADDR_OFF = 8'h00;
    localparam logic [7:0] UFA_DEV_CTRL_OFF  = 8'h04;
    localparam logic [7:0] UFA_IRQ_FLAG_OFF  = 8'h08;
    localparam logic [7:0] UFA_IRQ_EN_OFF    = 8'h0C;
    localparam logic [7:0] UFA_INDEX_OFF     = 8'h10;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int UFA_PEND_BIT    = 7;
    localparam int UFA_ISO_BIT     = 7;
    localparam int UFA_INH_BIT     = 4;
    localparam int UFA_BRST_BIT    = 3;
    localparam int UFA_WAKE_BIT    = 2;
    localparam int UFA_SUSP_BIT    = 1;
    localparam int UFA_SUSPEND_DETECT_ENABLE_BIT   = 0;
    localparam int UFA_IRQ_SUSP    = 0;
    localparam int UFA_IRQ_RESUME  = 1;
    localparam int UFA_IRQ_RESET   = 2;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [6:0] UFA_ADDR_RST   = 7'h00;
    localparam logic [7:0] UFA_CTRL_RST   = 8'h10;
    localparam logic [2:0] UFA_IEN_RST    = 3'h6;
    localparam logic [2:0] UFA_IEN_BUSRST = 3'h6;
    localparam logic [3:0] UFA_INDEX_RST  = 4'h0;
    // ****************************************
    // Timing
    // ****************************************
    localparam int UFA_CLK_NS      = 100;
    localparam int UFA_SRST_NS     = 400;
    localparam int UFA_SRST_CYC    = (UFA_SRST_NS + UFA_CLK_NS - 1) / UFA_CLK_NS;
endpackage : ufa_pkg

// ### dv/ufa_host_model.sv
/*
 Host side model: serial engine event pulses and token packets.
 Assumes the bench calls its tasks; every event lasts one mclk cycle.
*/
`timescale 1ns/100ps
module ufa_host_model (
    // Clock
    input  wire logic       mclk,
    // Events
    output logic            bus_reset_seen,
    output logic            suspend_seen,
    output logic            resume_seen,
    output logic            transfer_done,
    output logic            sof_seen,
    output logic            iso_loaded,
    output logic            iso_in_token,
    output logic            token_valid,
    output logic [6:0]      token_addr
);
    logic [7:0] ev = 8'h00;
    assign {token_valid, iso_in_token, iso_loaded, sof_seen} = ev[7:4];
    assign {transfer_done, resume_seen, suspend_seen, bus_reset_seen} = ev[3:0];
    initial token_addr = 7'h7F;
    task automatic pulse(input int idx);
        @(posedge mclk);
        ev[idx] <= 1'b1;
        @(posedge mclk);
        ev <= 8'h00;
    endtask : pulse
    task automatic token(input logic [6:0] a);
        @(posedge mclk);
        token_addr <= a;
        ev[7]      <= 1'b1;
        @(posedge mclk);
        ev         <= 8'h00;
        // Field is stale outside a token, so never leave the old address
        token_addr <= ~a;
    endtask : token
endmodule : ufa_host_model

// ### dv/usb_function_addr_and_device_control_bench.sv
/*
 Bench for ufa_core: Wishbone register tasks, host events, compares.
 Assumes the host model in ufa_host_model and the ufa_pkg constants.
*/
`timescale 1ns/100ps
module usb_function_addr_and_device_control_bench
    import ufa_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic        mclk = 1'b0, reset = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, brs, sus, res, tdn, sof, isl, iit, tkv;
    logic [6:0]  tka;
    logic        acc, isz, isr, ffl, epc, drs, osc, len, spd, irq;
    int          errors = 0, num_checks = 0, pc[6], base[6];
    always #50 mclk = ~mclk;
    ufa_core u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .bus_reset_seen(brs), .suspend_seen(sus),
        .resume_seen(res), .transfer_done(tdn), .sof_seen(sof), .iso_loaded(isl),
        .iso_in_token(iit), .token_valid(tkv), .token_addr(tka), .token_accept(acc),
        .iso_send_zero(isz), .iso_release(isr), .fifo_flush(ffl),
        .ep_regs_clear(epc), .drive_resume(drs), .osc_wake(osc),
        .link_enabled(len), .suspended(spd), .irq_out(irq));
    ufa_host_model u_host (.mclk(mclk), .bus_reset_seen(brs), .suspend_seen(sus),
        .resume_seen(res), .transfer_done(tdn), .sof_seen(sof), .iso_loaded(isl),
        .iso_in_token(iit), .token_valid(tkv), .token_addr(tka));
    // Pulse counters: order acc, isz, isr, ffl, epc, osc
    wire [5:0]   pv = {osc, epc, ffl, isr, isz, acc};
    always @(posedge mclk) begin
        foreach (pc[i]) if (pv[i] === 1'b1) pc[i]++;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge mclk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (ack === 1'b1) break;
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        if (n == 20) begin
            errors++;
            report_and_stop();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    task automatic mark();
        idle(3);
        base = pc;
    endtask : mark
    task automatic delta(input int i, input int exp);
        idle(3);
        chk(pc[i] - base[i], exp);
    endtask : delta
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        idle(10);
        reset <= 1'b0;
        rd(UFA_DEV_CTRL_OFF, 32'h10);
        rd(UFA_FUNC_ADDR_OFF, 32'h00);
        rd(UFA_IRQ_EN_OFF, 32'h06);
        chk(len, 0);
        wr(UFA_DEV_CTRL_OFF, 8'h08);
        idle(UFA_SRST_CYC + 2);
        rd(UFA_DEV_CTRL_OFF, 32'h10);
        wr(UFA_IRQ_EN_OFF, 8'h06);
        wr(UFA_DEV_CTRL_OFF, 8'h00);
        chk(len, 1);
        wr(UFA_DEV_CTRL_OFF, 8'h10);
        rd(UFA_DEV_CTRL_OFF, 32'h00);
        wr(UFA_FUNC_ADDR_OFF, 8'h05);
        rd(UFA_FUNC_ADDR_OFF, 32'h85);
        mark();
        u_host.token(7'h05);
        delta(0, 0);
        u_host.token(7'h00);
        delta(0, 1);
        u_host.pulse(3);
        rd(UFA_FUNC_ADDR_OFF, 32'h05);
        sel <= 4'hE;
        wr(UFA_FUNC_ADDR_OFF, 8'h22);
        sel <= 4'hF;
        rd(UFA_FUNC_ADDR_OFF, 32'h05);
        mark();
        u_host.token(7'h05);
        u_host.token(7'h06);
        delta(0, 1);
        u_host.pulse(1);
        idle(3);
        chk(spd, 0);
        wr(UFA_DEV_CTRL_OFF, 8'h01);
        u_host.pulse(1);
        rd(UFA_DEV_CTRL_OFF, 32'h03);
        mark();
        u_host.pulse(2);
        delta(5, 1);
        chk(spd, 0);
        rd(UFA_IRQ_FLAG_OFF, 32'h02);
        rd(UFA_IRQ_FLAG_OFF, 32'h00);
        wr(UFA_IRQ_EN_OFF, 8'h07);
        wr(UFA_INDEX_OFF, 8'h03);
        rd(UFA_INDEX_OFF, 32'h03);
        u_host.pulse(1);
        rd(UFA_IRQ_FLAG_OFF, 32'h01);
        mark();
        u_host.pulse(0);
        delta(3, 1);
        chk(pc[4] - base[4], 1);
        chk(spd, 0);
        rd(UFA_DEV_CTRL_OFF, 32'h09);
        rd(UFA_FUNC_ADDR_OFF, 32'h00);
        rd(UFA_INDEX_OFF, 32'h00);
        rd(UFA_IRQ_EN_OFF, 32'h07);
        chk(irq, 1);
        rd(UFA_IRQ_FLAG_OFF, 32'h04);
        chk(irq, 0);
        wr(UFA_DEV_CTRL_OFF, 8'h05);
        chk(drs, 1);
        wr(UFA_DEV_CTRL_OFF, 8'h01);
        chk(drs, 0);
        wr(UFA_DEV_CTRL_OFF, 8'h81);
        mark();
        u_host.pulse(5);
        u_host.pulse(6);
        delta(1, 1);
        u_host.pulse(4);
        delta(2, 1);
        rd(8'h20, 32'h00);
        wr(UFA_DEV_CTRL_OFF, 8'h08);
        idle(UFA_SRST_CYC + 2);
        chk(len, 0);
        report_and_stop();
    end
endmodule : usb_function_addr_and_device_control_bench
